// >>> serial_route_pkg.sv
/*
 * serial_route_pkg: register map, field positions and reset values for the
 * async serial configuration and routing block.
 * assumes: 32-bit APB, one register per aligned word.
 */
package serial_route_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] SERIAL_CLOCK_MODEM_SELECT_OFFSET = 16'hF836;
    // printed offset is not a multiple of four: byte address = 4 * index
    localparam logic [17:0] SERIAL_CLOCK_MODEM_SELECT_ADDR   =
        {SERIAL_CLOCK_MODEM_SELECT_OFFSET, 2'b00};
    localparam logic [17:0] ROUTE_STATUS_ADDR               = 18'h3FFF0;
    localparam logic [7:0]  SERIAL_CLOCK_MODEM_SELECT_RESET = 8'h00;
    localparam logic [7:0]  CFG_WRITABLE_MASK               = 8'hC7;
    // synchroniser reset: clock levels low, active-low modem lines idle high
    localparam logic [17:0] PIN_SYNC_IDLE                   = 18'h0FFFF;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CHAN1_MODEM_INTERNAL_BIT    = 7;
    localparam int CHAN0_MODEM_INTERNAL_BIT    = 6;
    localparam int SYNC_BAUD_CLOCK_SELECT_BIT  = 2;
    localparam int CHAN1_BAUD_CLOCK_SELECT_BIT = 1;
    localparam int CHAN0_BAUD_CLOCK_SELECT_BIT = 0;
    // interrupt source encodings: none first, then highest priority first
    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_LINE_STATUS,
        SRC_RX_FULL,
        SRC_TX_EMPTY,
        SRC_MODEM
    } irq_source_type;
endpackage

// >>> irq_priority_select.sv
/*
 * irq_priority_select: fixed priority choice among a channel's four
 * status signals; the output level equals the chosen status signal.
 * assumes: status inputs are synchronous to pclk.
 */
`timescale 1ns/1ns
module irq_priority_select
    import serial_route_pkg::*;
(
    // clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // status signals
    input  wire logic           line_status,
    input  wire logic           rx_full,
    input  wire logic           tx_empty,
    input  wire logic           modem_status,
    // result
    output irq_source_type      source,
    output logic                irq
);
    irq_source_type source_r;
    irq_source_type source_nxt;
    logic           irq_r;
    logic           irq_nxt;

    always_comb
    begin
        if (line_status)
            source_nxt = SRC_LINE_STATUS;
        else if (rx_full)
            source_nxt = SRC_RX_FULL;
        else if (tx_empty)
            source_nxt = SRC_TX_EMPTY;
        else if (modem_status)
            source_nxt = SRC_MODEM;
        else
            source_nxt = SRC_NONE;
        unique case (source_nxt)
            SRC_LINE_STATUS: irq_nxt = line_status;
            SRC_RX_FULL:     irq_nxt = rx_full;
            SRC_TX_EMPTY:    irq_nxt = tx_empty;
            SRC_MODEM:       irq_nxt = modem_status;
            default:         irq_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            source_r <= SRC_NONE;
            irq_r    <= 1'b0;
        end
        else
        begin
            source_r <= source_nxt;
            irq_r    <= irq_nxt;
        end
    end

    assign source = source_r;
    assign irq    = irq_r;

    property p_irq_follows;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> irq == ($past(line_status) | $past(rx_full) | $past(tx_empty)
                         | $past(modem_status));
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("interrupt does not follow selected status");

    property p_line_first;
        @(posedge pclk) disable iff (!presetn)
        line_status |=> source == SRC_LINE_STATUS;
    endproperty
    a_line_first: assert property (p_line_first)
        else $error("line status not given top priority");

    property p_modem_last;
        @(posedge pclk) disable iff (!presetn)
        (modem_status && !line_status && !rx_full && !tx_empty) |=> source == SRC_MODEM;
    endproperty
    a_modem_last: assert property (p_modem_last)
        else $error("modem status not selected when alone");
endmodule

// >>> async_serial_config_routing.sv
/*
 * async_serial_config_routing: configuration register and signal routing
 * for two async serial channels and the sync serial unit's baud clock.
 * assumes: APB master on pclk; pins arrive asynchronously; baud clock
 * selection is a data mux of sampled levels, not a glitch-free clock mux.
 */
// Added by the designer: the APB register port.
// Operation
// - channel interrupts go only to interrupt controller; here they are also readable in status register bits 1:0
// - interrupt equals status chosen by priority
// - channel zero pins shared with port signals
// - bit 7 routes channel one modem inputs
// - bit 1 picks channel one baud clock
`timescale 1ns/1ns
module async_serial_config_routing
    import serial_route_pkg::*;
(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // clock sources
    input  wire logic        internal_serial_clock,
    input  wire logic        external_comm_clock_pin,
    output logic             chan0_baud_clock,
    output logic             chan1_baud_clock,
    output logic             sync_baud_clock,
    // modem inputs: pins and internal loop sources, {dcd,ri,dsr,cts}
    input  wire logic [3:0]  chan0_modem_pins_n,
    input  wire logic [3:0]  chan0_modem_loop_n,
    input  wire logic [3:0]  chan1_modem_pins_n,
    input  wire logic [3:0]  chan1_modem_loop_n,
    output logic [3:0]       chan0_modem_in_n,
    output logic [3:0]       chan1_modem_in_n,
    // channel status, same clock
    input  wire logic [3:0]  chan0_status,
    input  wire logic [3:0]  chan1_status,
    // to interrupt controller, also readable in status register bits 1:0
    output logic             chan0_irq,
    output logic             chan1_irq,
    // pin sharing
    input  wire logic        chan0_enable,
    input  wire logic        chan1_enable,
    input  wire logic        chan1_modem_enable,
    output logic             chan0_owns_pins,
    output logic             chan1_owns_pins,
    output logic             chan1_modem_owns_pins,
    output logic             pin_conflict
);
    // ------------------------------------------------------------
    // pin synchronisers: three stages, change counts once 2 and 3 agree
    // ------------------------------------------------------------
    localparam int SYNC_W = 18;
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] s1_r, s2_r, s3_r, clean_r;
    logic [SYNC_W-1:0] clean_nxt;

    assign raw = {external_comm_clock_pin, internal_serial_clock,
                  chan0_modem_pins_n, chan1_modem_pins_n,
                  chan0_modem_loop_n, chan1_modem_loop_n};

    always_comb
    begin
        clean_nxt = clean_r;
        for (int i = 0; i < SYNC_W; i++)
            if (s2_r[i] == s3_r[i])
                clean_nxt[i] = s3_r[i];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // idle levels, so no modem line looks active just after reset
            s1_r    <= PIN_SYNC_IDLE;
            s2_r    <= PIN_SYNC_IDLE;
            s3_r    <= PIN_SYNC_IDLE;
            clean_r <= PIN_SYNC_IDLE;
        end
        else
        begin
            s1_r    <= raw;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            clean_r <= clean_nxt;
        end
    end

    logic       ext_clk_s, int_clk_s;
    logic [3:0] c0_pin_s, c1_pin_s, c0_loop_s, c1_loop_s;
    assign {ext_clk_s, int_clk_s, c0_pin_s, c1_pin_s, c0_loop_s, c1_loop_s} = clean_r;

    // ------------------------------------------------------------
    // apb register
    // ------------------------------------------------------------
    logic [7:0]  cfg_r, cfg_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        hit_cfg, hit_stat, access;

    assign access   = psel && penable;
    assign hit_cfg  = paddr == SERIAL_CLOCK_MODEM_SELECT_ADDR;
    assign hit_stat = paddr == ROUTE_STATUS_ADDR;
    // zero-wait slave; unmapped addresses answer with an error
    assign pready   = 1'b1;
    assign pslverr  = access && !hit_cfg && !(hit_stat && !pwrite);

    always_comb
    begin
        cfg_nxt    = cfg_r;
        prdata_nxt = prdata_r;
        if (access && pwrite && hit_cfg)
            cfg_nxt = pwdata[7:0] & CFG_WRITABLE_MASK;
        if (psel && !penable && !pwrite)
        begin
            if (hit_cfg)
                prdata_nxt = {24'h000000, cfg_r};
            else if (hit_stat)
                prdata_nxt = {26'h0000000, pin_conflict, chan1_modem_owns_pins,
                              chan1_owns_pins, chan0_owns_pins, chan1_irq, chan0_irq};
            else
                prdata_nxt = 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_r    <= SERIAL_CLOCK_MODEM_SELECT_RESET;
            prdata_r <= 32'h00000000;
        end
        else
        begin
            cfg_r    <= cfg_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;

    // ------------------------------------------------------------
    // routing, registered
    // ------------------------------------------------------------
    logic [2:0] baud_r, baud_nxt;
    logic [7:0] modem_r, modem_nxt;
    logic [3:0] own_r, own_nxt;

    function automatic logic pick(input logic sel, input logic a, input logic b);
        pick = sel ? a : b;
    endfunction

    always_comb
    begin
        baud_nxt[0] = pick(cfg_r[CHAN0_BAUD_CLOCK_SELECT_BIT], int_clk_s, ext_clk_s);
        baud_nxt[1] = pick(cfg_r[CHAN1_BAUD_CLOCK_SELECT_BIT], int_clk_s, ext_clk_s);
        baud_nxt[2] = pick(cfg_r[SYNC_BAUD_CLOCK_SELECT_BIT], int_clk_s, ext_clk_s);
        modem_nxt[3:0] = cfg_r[CHAN0_MODEM_INTERNAL_BIT] ? c0_loop_s : c0_pin_s;
        modem_nxt[7:4] = cfg_r[CHAN1_MODEM_INTERNAL_BIT] ? c1_loop_s : c1_pin_s;
        // channel zero takes its pins from the port function when enabled
        own_nxt[0] = chan0_enable;
        own_nxt[1] = chan1_enable;
        own_nxt[2] = chan1_modem_enable;
        // a sync-unit/DMA user cannot be seen here; flag channel one modem
        // use without channel one, which software should not set up
        own_nxt[3] = chan1_modem_enable && !chan1_enable;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            baud_r  <= 3'b000;
            modem_r <= 8'hFF;
            own_r   <= 4'h0;
        end
        else
        begin
            baud_r  <= baud_nxt;
            modem_r <= modem_nxt;
            own_r   <= own_nxt;
        end
    end

    assign chan0_baud_clock      = baud_r[0];
    assign chan1_baud_clock      = baud_r[1];
    assign sync_baud_clock       = baud_r[2];
    assign chan0_modem_in_n      = modem_r[3:0];
    assign chan1_modem_in_n      = modem_r[7:4];
    assign chan0_owns_pins       = own_r[0];
    assign chan1_owns_pins       = own_r[1]; // DMA 1 must stay off meanwhile
    assign chan1_modem_owns_pins = own_r[2];
    assign pin_conflict          = own_r[3];

    // ------------------------------------------------------------
    // interrupt selection; outputs go to the controller, never to pins
    // ------------------------------------------------------------
    irq_priority_select u_irq0 (
        .pclk         (pclk),
        .presetn      (presetn),
        .line_status  (chan0_status[0]),
        .rx_full      (chan0_status[1]),
        .tx_empty     (chan0_status[2]),
        .modem_status (chan0_status[3]),
        .source       (),
        .irq          (chan0_irq)
    );

    irq_priority_select u_irq1 (
        .pclk         (pclk),
        .presetn      (presetn),
        .line_status  (chan1_status[0]),
        .rx_full      (chan1_status[1]),
        .tx_empty     (chan1_status[2]),
        .modem_status (chan1_status[3]),
        .source       (),
        .irq          (chan1_irq)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_cfg_write;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && hit_cfg) |=> cfg_r == ($past(pwdata[7:0]) & CFG_WRITABLE_MASK);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("configuration write not stored");

    property p_chan1_modem;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> chan1_modem_in_n == ($past(cfg_r[7]) ? $past(c1_loop_s) : $past(c1_pin_s));
    endproperty
    a_chan1_modem: assert property (p_chan1_modem)
        else $error("channel one modem routing wrong");

    property p_chan0_modem;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> chan0_modem_in_n == ($past(cfg_r[6]) ? $past(c0_loop_s) : $past(c0_pin_s));
    endproperty
    a_chan0_modem: assert property (p_chan0_modem)
        else $error("channel zero modem routing wrong");

    property p_chan1_baud;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> chan1_baud_clock == ($past(cfg_r[1]) ? $past(int_clk_s) : $past(ext_clk_s));
    endproperty
    a_chan1_baud: assert property (p_chan1_baud)
        else $error("channel one baud source wrong");

    property p_sync_baud;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> sync_baud_clock == ($past(cfg_r[2]) ? $past(int_clk_s) : $past(ext_clk_s));
    endproperty
    a_sync_baud: assert property (p_sync_baud)
        else $error("sync unit baud source wrong");

    property p_chan0_pins;
        @(posedge pclk) disable iff (!presetn)
        chan0_enable |=> chan0_owns_pins;
    endproperty
    a_chan0_pins: assert property (p_chan0_pins)
        else $error("channel zero did not take its pins");

    property p_conflict;
        @(posedge pclk) disable iff (!presetn)
        (chan1_modem_enable && !chan1_enable) |=> pin_conflict;
    endproperty
    a_conflict: assert property (p_conflict)
        else $error("pin conflict not flagged");

    property p_irq_only_status;
        @(posedge pclk) disable iff (!presetn)
        (chan1_status == 4'h0) |=> !chan1_irq;
    endproperty
    a_irq_only_status: assert property (p_irq_only_status)
        else $error("channel one interrupt without status");

    c_cfg_write: cover property (@(posedge pclk) access && pwrite && hit_cfg);
    c_cfg_read:  cover property (@(posedge pclk) access && !pwrite && hit_cfg);
    c_irq1:      cover property (@(posedge pclk) chan1_irq);
    c_unmapped:  cover property (@(posedge pclk) pslverr);
endmodule

// >>> far_side_model.sv
/*
 * far_side_model: clock pins and interrupt controller beside the routing block.
 * assumes: pclk runs well above both serial clocks; bench owns freeze.
 */
`timescale 1ns/1ns
module far_side_model
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // bench control: hold clocks at opposite levels
    input  wire logic freeze,
    // clock sources
    output logic      internal_serial_clock,
    output logic      external_comm_clock_pin,
    // interrupt controller inputs
    input  wire logic chan0_irq,
    input  wire logic chan1_irq,
    output int        irq_events
);
    int   cnt;
    logic irq0_q;
    logic irq1_q;

    // -------------------------------------------------------
    // clocks: unequal rates so a swapped select shows up
    // -------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt                     <= 0;
            internal_serial_clock   <= 1'b1;
            external_comm_clock_pin <= 1'b0;
        end
        else
        begin
            cnt                     <= cnt + 1;
            internal_serial_clock   <= freeze ? 1'b1 : ((cnt % 6) < 3);
            external_comm_clock_pin <= freeze ? 1'b0 : ((cnt % 10) < 5);
        end
    end

    // -------------------------------------------------------
    // interrupt controller: counts rising edges of both channels in one total
    // -------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_events <= 0;
            irq0_q     <= 1'b0;
            irq1_q     <= 1'b0;
        end
        else
        begin
            irq0_q     <= chan0_irq;
            irq1_q     <= chan1_irq;
            irq_events <= irq_events + int'(chan0_irq & !irq0_q)
                          + int'(chan1_irq & !irq1_q);
        end
    end
endmodule

// >>> test_async_serial_config_routing.sv
/*
 * test_async_serial_config_routing: self-checking bench for the routing block.
 * assumes: far_side_model drives the clock pins; apb is zero wait.
 */
`timescale 1ns/1ns
module test_async_serial_config_routing
    import serial_route_pkg::*;
();
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, freeze;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        isc, ecp, b0, b1, bs, i0, i1, c0e, c1e, c1me, o0, o1, o1m, conf, err;
    logic        q0, q1;
    int          n0, n1;
    logic [3:0]  p0, l0, p1, l1, m0, m1, s0, s1;
    int          errors, total_checks, seed, ev, exp_ev, cfg, k;
    int          cfg_list[$] = '{'h00, 'h80, 'h40, 'hC0, 'h07, 'h01, 'h02, 'h04, 'hFF};

    async_serial_config_routing DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .internal_serial_clock(isc), .external_comm_clock_pin(ecp),
        .chan0_baud_clock(b0), .chan1_baud_clock(b1), .sync_baud_clock(bs),
        .chan0_modem_pins_n(p0), .chan0_modem_loop_n(l0), .chan1_modem_pins_n(p1),
        .chan1_modem_loop_n(l1), .chan0_modem_in_n(m0), .chan1_modem_in_n(m1),
        .chan0_status(s0), .chan1_status(s1), .chan0_irq(i0), .chan1_irq(i1),
        .chan0_enable(c0e), .chan1_enable(c1e), .chan1_modem_enable(c1me),
        .chan0_owns_pins(o0), .chan1_owns_pins(o1), .chan1_modem_owns_pins(o1m),
        .pin_conflict(conf));
    far_side_model far (.pclk(pclk), .presetn(presetn), .freeze(freeze),
        .internal_serial_clock(isc), .external_comm_clock_pin(ecp),
        .chan0_irq(i0), .chan1_irq(i1), .irq_events(ev));

    always #50 pclk = !pclk;

    // -------------------------------------------------------
    // shared tasks
    // -------------------------------------------------------
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // holds the request until pready is sampled high at a rising edge
    task apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #(100 * 20000);
        errors++;
        give_verdict();
    end

    // -------------------------------------------------------
    // main sequence
    // -------------------------------------------------------
    initial
    begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
        pwdata = '0; freeze = 1; p0 = 4'hF; l0 = 4'hF; p1 = 4'hF; l1 = 4'hF;
        s0 = 4'h0; s1 = 4'h0; c0e = 0; c1e = 0; c1me = 0;
        errors = 0; total_checks = 0; seed = 51224; exp_ev = 0;
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        chk("reset modem0", 32'hF, {28'h0, m0});
        chk("reset irq", 32'h0, {30'h0, i1, i0});
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, SERIAL_CLOCK_MODEM_SELECT_ADDR, 32'h0);
        chk("cfg reset", 32'h00, rd);
        for (k = 0; k < 6; k++)
        begin
            cfg = $random(seed);
            apb(1'b1, SERIAL_CLOCK_MODEM_SELECT_ADDR, 32'(cfg));
            apb(1'b0, SERIAL_CLOCK_MODEM_SELECT_ADDR, 32'h0);
            chk("cfg readback", 32'(cfg & 'hC7), rd);
        end
        $display("register test done");
        foreach (cfg_list[j])
        begin
            apb(1'b1, SERIAL_CLOCK_MODEM_SELECT_ADDR, 32'(cfg_list[j]));
            chk("cfg err", 32'h0, {31'h0, err});
            p0 <= 4'($random(seed)); l0 <= 4'($random(seed));
            p1 <= 4'($random(seed)); l1 <= 4'($random(seed));
            settle(8);
            chk("modem1", {28'h0, cfg_list[j][7] ? l1 : p1}, {28'h0, m1});
            chk("modem0", {28'h0, cfg_list[j][6] ? l0 : p0}, {28'h0, m0});
            chk("baud1", 32'(cfg_list[j][1]), {31'h0, b1});
            chk("baud0 sync", 32'(cfg_list[j] & 5), {29'h0, bs, 1'b0, b0});
        end
        $display("routing test done");
        // free-running sources: internal toggles every 3 cycles, pin every 5
        freeze <= 1'b0;
        apb(1'b1, SERIAL_CLOCK_MODEM_SELECT_ADDR, 32'h02);
        n0 = 0;
        n1 = 0;
        q0 = b0;
        q1 = b1;
        repeat (120)
        begin
            @(negedge pclk);
            n0 += int'(b0 != q0);
            n1 += int'(b1 != q1);
            q0 = b0;
            q1 = b1;
        end
        chk("baud rates", 32'h1, 32'(n1 > n0));
        $display("baud clock test done");
        for (k = 0; k < 16; k++)
        begin
            s0 <= 4'(k);
            s1 <= ~4'(k);
            settle(2);
            exp_ev += (k == 0) ? 1 : (k == 1) ? 1 : 0;
            chk("irq0", 32'(k != 0), {31'h0, i0});
            chk("irq1", 32'(k != 15), {31'h0, i1});
        end
        chk("irq events", 32'(exp_ev), 32'(ev));
        s1 <= 4'h0;
        $display("interrupt test done");
        for (k = 0; k < 8; k++)
        begin
            {c1me, c1e, c0e} <= 3'(k);
            settle(2);
            chk("owns", 32'(k), {29'h0, o1m, o1, o0});
            chk("conflict", 32'(k == 4 || k == 5), {31'h0, conf});
            apb(1'b0, ROUTE_STATUS_ADDR, 32'h0);
            chk("status reg", 32'((k << 2) | ((k == 4 || k == 5) ? 'h20 : 0) | 1), rd);
        end
        $display("pin sharing test done");
        apb(1'b0, 18'h00100, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, ROUTE_STATUS_ADDR, 32'hFF);
        chk("status write", 32'h1, {31'h0, err});
        $display("refusal test done");
        give_verdict();
    end
endmodule
